/* hw/csls_pkg.sv */
// Shared types and constants of the card select and lane steering block.
// Assumes a single core clock; host pins are synchronised in the top.
package csls_pkg;

  // Operating mode, driven by core logic on the same clock
  typedef enum logic [1:0] {
    MODE_MEM,
    MODE_IO,
    MODE_IDE
  } csls_mode_t;

  // Decoded access kind
  typedef enum logic [2:0] {
    K_NONE,
    K_WORD,
    K_EVEN,
    K_ODD_LO,
    K_ODD_HI,
    K_TASK,
    K_CTRL,
    K_DMA
  } csls_kind_t;

  // Host pins as one synchronised vector
  typedef struct packed {
    logic        even_en_n; // even lane enable, task file select in IDE
    logic        odd_en_n;  // odd lane enable, control block select in IDE
    logic        offset;    // byte offset bit
    logic [2:0]  addr;      // register index lines
    logic        role_n;    // role select
    logic        grant_n;   // DMA grant
    logic        rd_n;     // host reads when low
    logic [15:0] data;     // data bus lanes
  } csls_pins_t;

  // Result of the decode
  typedef struct packed {
    csls_kind_t kind;
    logic [1:0] be;
    logic       tf;
    logic       cb;
    logic [2:0] idx;
  } csls_dec_t;

  localparam int         BYTE_W       = 8;
  localparam logic [15:0] LANES_ALL   = 16'hFFFF;
  localparam logic [15:0] LANES_LO    = 16'h00FF;
  localparam logic [15:0] LANES_HI    = 16'hFF00;
  localparam logic [15:0] LANES_NONE  = 16'h0000;
  localparam logic [1:0]  BE_NONE     = 2'h0;
  localparam logic [1:0]  BE_EVEN     = 2'h1;
  localparam logic [1:0]  BE_ODD      = 2'h2;
  localparam logic [1:0]  BE_WORD     = 2'h3;
  localparam logic [2:0]  IDX_ZERO    = 3'h0;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [2:0]  ROLE_SETTLE = 3'h4;
  localparam logic [2:0]  CNT_ONE     = 3'h1;
  localparam csls_pins_t  PINS_IDLE   = '{even_en_n: 1'b1, odd_en_n: 1'b1,
                                          offset: 1'b0, addr: 3'h0,
                                          role_n: 1'b1, grant_n: 1'b1,
                                          rd_n: 1'b1, data: 16'h0000};
  localparam csls_dec_t   DEC_IDLE    = '{kind: K_NONE, be: 2'h0,
                                          tf: 1'b0, cb: 1'b0,
                                          idx: 3'h0};

endpackage : csls_pkg

/* hw/csls_top.sv */
// Card-side select decode, byte lane steering and role strapping.
// Assumes host pins arrive asynchronously and core data on CORE_CLK_IN.
//
// What this block does
// - Outside IDE mode the two lane enables select the card and size it.
// - Outside IDE mode an asserted odd-lane enable always reaches the odd byte of the word.
// - Outside IDE mode, with only the even-lane enable, the offset bit picks even or odd.
// - Outside IDE mode, offset and enables let an 8-bit host reach every byte on lanes 7..0.
// - In IDE mode the task file select addresses the task file registers.
// - In IDE mode the control block select reaches alt status and control.
// - In IDE mode the pulled-up role select fixes master or slave role.
// - In IDE mode a grounded role select gives the master role.
// - An open role select gives the slave role.
// - Lane 0 is the even byte LSB and lane 8 the odd byte LSB.
// - IDE task file accesses are bytes on the low eight lanes.
// - IDE data transfers are full sixteen-bit words.
// - In IDE mode the three lowest address lines pick one of eight registers.
`timescale 1ns/1ps
`default_nettype none

module csls_top
  import csls_pkg::*;
(
  // Clock and reset
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RST_N_IN,
  // Mode from core logic
  input  wire csls_pkg::csls_mode_t CARD_MODE_IN,
  // Host pins
  input  wire logic               EVEN_LANE_ENABLE_N_IN,
  input  wire logic               ODD_LANE_ENABLE_N_IN,
  input  wire logic               BYTE_OFFSET_BIT_IN,
  input  wire logic [2:0]         REG_ADDR_IN,
  input  wire logic               ROLE_SELECT_N_IN,
  input  wire logic               DMA_GRANT_N_IN,
  input  wire logic               HOST_READ_N_IN,
  input  wire logic [15:0]        DATA_BUS_LANES_IN,
  output logic [15:0]             DATA_BUS_LANES_OUT,
  output logic [15:0]             DATA_BUS_LANES_OE_OUT,
  // Core side
  input  wire logic [15:0]        CORE_RD_DATA_IN,
  output logic [15:0]             CORE_WR_DATA_OUT,
  output logic [1:0]              CORE_BYTE_EN_OUT,
  output csls_pkg::csls_kind_t    ACCESS_KIND_OUT,
  output logic                    TASKFILE_SEL_OUT,
  output logic                    CONTROL_SEL_OUT,
  output logic [2:0]              REG_INDEX_OUT,
  output logic                    ROLE_MASTER_OUT
);
  import csls_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, a bit changes once stages 2 and 3 agree

  csls_pins_t pins;
  csls_pins_t s1_q, s2_q, s3_q, stab_q;
  csls_pins_t s1_d, s2_d, s3_d, stab_d;

  assign pins = '{even_en_n: EVEN_LANE_ENABLE_N_IN,
                  odd_en_n: ODD_LANE_ENABLE_N_IN,
                  offset: BYTE_OFFSET_BIT_IN, addr: REG_ADDR_IN,
                  role_n: ROLE_SELECT_N_IN, grant_n: DMA_GRANT_N_IN,
                  rd_n: HOST_READ_N_IN, data: DATA_BUS_LANES_IN};

  always_comb begin
    s1_d   = pins;
    s2_d   = s1_q;
    s3_d   = s2_q;
    stab_d = (s2_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s1_q   <= PINS_IDLE;
      s2_q   <= PINS_IDLE;
      s3_q   <= PINS_IDLE;
      stab_q <= PINS_IDLE;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      stab_q <= stab_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Select decode

  logic      ide;
  csls_dec_t dec;

  assign ide = (CARD_MODE_IN == MODE_IDE);

  always_comb begin
    dec = DEC_IDLE;
    if (ide) begin
      if (!stab_q.grant_n) begin
        // Selects are the host's to keep negated here; grant wins anyway
        dec.kind = K_DMA;
        dec.be   = BE_WORD;
      end else if (!stab_q.even_en_n && stab_q.odd_en_n) begin
        dec.kind = K_TASK;
        dec.tf   = 1'b1;
        dec.be   = BE_EVEN;
        dec.idx  = stab_q.addr;
      end else if (stab_q.even_en_n && !stab_q.odd_en_n) begin
        dec.kind = K_CTRL;
        dec.cb   = 1'b1;
        dec.be   = BE_EVEN;
        dec.idx  = stab_q.addr;
      end else if (!stab_q.even_en_n && !stab_q.odd_en_n) begin
        // Both selects with no grant: taken as a data word
        dec.kind = K_WORD;
        dec.be   = BE_WORD;
      end
    end else begin
      case ({stab_q.odd_en_n, stab_q.even_en_n})
        2'b00: begin
          dec.kind = K_WORD;
          dec.be   = BE_WORD;
        end
        2'b01: begin
          dec.kind = K_ODD_HI;
          dec.be   = BE_ODD;
        end
        2'b10: begin
          dec.kind = stab_q.offset ? K_ODD_LO : K_EVEN;
          dec.be   = stab_q.offset ? BE_ODD : BE_EVEN;
        end
        default: begin
          dec = DEC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lane steering, registered onto the outputs

  logic [15:0] dout_q, dout_d, oe_q, oe_d, wr_q, wr_d;
  csls_dec_t   dec_q;
  logic [15:0] rd, bus;

  assign rd  = CORE_RD_DATA_IN;
  assign bus = stab_q.data;

  always_comb begin
    dout_d = {BYTE_ZERO, rd[BYTE_W-1:0]};
    wr_d   = {BYTE_ZERO, bus[BYTE_W-1:0]};
    oe_d   = LANES_LO;
    case (dec.kind)
      K_WORD, K_DMA: begin
        dout_d = rd;
        wr_d   = bus;
        oe_d   = LANES_ALL;
      end
      K_ODD_LO: begin
        // Odd byte folded down so an 8-bit host sees it on lanes 7..0
        dout_d = {BYTE_ZERO, rd[15:BYTE_W]};
        wr_d   = {bus[BYTE_W-1:0], BYTE_ZERO};
      end
      K_ODD_HI: begin
        dout_d = {rd[15:BYTE_W], BYTE_ZERO};
        wr_d   = {bus[15:BYTE_W], BYTE_ZERO};
        oe_d   = LANES_HI;
      end
      K_EVEN, K_TASK, K_CTRL: begin
        oe_d = LANES_LO;
      end
      default: begin
        dout_d = LANES_NONE;
        wr_d   = LANES_NONE;
        oe_d   = LANES_NONE;
      end
    endcase
    if (stab_q.rd_n) begin
      oe_d = LANES_NONE;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dout_q <= LANES_NONE;
      oe_q   <= LANES_NONE;
      wr_q   <= LANES_NONE;
      dec_q  <= DEC_IDLE;
    end else begin
      dout_q <= dout_d;
      oe_q   <= oe_d;
      wr_q   <= wr_d;
      dec_q  <= dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Role strap: caught once the synchroniser has settled after reset.
  // Latching avoids a role flip from noise on a pin that is only strapped.

  logic [2:0] cnt_q, cnt_d;
  logic       lock_q, lock_d, master_q, master_d, role_q, role_d;

  always_comb begin
    cnt_d    = cnt_q;
    lock_d   = lock_q;
    master_d = master_q;
    if (!lock_q) begin
      master_d = !stab_q.role_n;
      cnt_d    = 3'(cnt_q + CNT_ONE);
      lock_d   = (cnt_q == ROLE_SETTLE);
    end
    role_d = ide && master_q;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt_q    <= IDX_ZERO;
      lock_q   <= 1'b0;
      master_q <= 1'b0;
      role_q   <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      lock_q   <= lock_d;
      master_q <= master_d;
      role_q   <= role_d;
    end
  end

  assign DATA_BUS_LANES_OUT    = dout_q;
  assign DATA_BUS_LANES_OE_OUT = oe_q;
  assign CORE_WR_DATA_OUT      = wr_q;
  assign CORE_BYTE_EN_OUT      = dec_q.be;
  assign ACCESS_KIND_OUT       = dec_q.kind;
  assign TASKFILE_SEL_OUT      = dec_q.tf;
  assign CONTROL_SEL_OUT       = dec_q.cb;
  assign REG_INDEX_OUT         = dec_q.idx;
  assign ROLE_MASTER_OUT       = role_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb_clk @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic past_ok_q;
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      past_ok_q <= 1'b0;
    end else begin
      past_ok_q <= 1'b1;
    end
  end

  card_sel_a: assert property (past_ok_q && !$past(ide)
    && !$past(stab_q.even_en_n) |-> ACCESS_KIND_OUT != K_NONE)
    else $error("even enable did not select the card");
  odd_route_a: assert property (past_ok_q && !$past(ide)
    && !$past(stab_q.odd_en_n) |-> CORE_BYTE_EN_OUT[1])
    else $error("odd enable missed the odd byte");
  even_pick_a: assert property (past_ok_q && !$past(ide)
    && !$past(stab_q.even_en_n) && $past(stab_q.odd_en_n) |->
    ACCESS_KIND_OUT == ($past(stab_q.offset) ? K_ODD_LO : K_EVEN))
    else $error("offset bit chose the wrong byte");
  low_mux_a: assert property (past_ok_q && ACCESS_KIND_OUT == K_ODD_LO
    |-> DATA_BUS_LANES_OUT[7:0] == $past(rd[15:8])
    && (DATA_BUS_LANES_OE_OUT & LANES_HI) == LANES_NONE)
    else $error("odd byte not folded to low lanes");
  task_sel_a: assert property (past_ok_q && $past(ide)
    && $past(stab_q.grant_n) && !$past(stab_q.even_en_n)
    && $past(stab_q.odd_en_n) |-> TASKFILE_SEL_OUT && !CONTROL_SEL_OUT)
    else $error("task file select not decoded");
  ctrl_sel_a: assert property (past_ok_q && $past(ide)
    && $past(stab_q.grant_n) && $past(stab_q.even_en_n)
    && !$past(stab_q.odd_en_n) |-> CONTROL_SEL_OUT && !TASKFILE_SEL_OUT)
    else $error("control block select not decoded");
  role_hold_a: assert property (lock_q |=> $stable(master_q))
    else $error("role changed after lock");
  role_master_a: assert property (!lock_q && !stab_q.role_n
    |=> master_q)
    else $error("grounded role select not master");
  role_slave_a: assert property (!lock_q && stab_q.role_n
    |=> !master_q ##1 !role_q)
    else $error("open role select not slave");
  lane_order_a: assert property (past_ok_q && ACCESS_KIND_OUT == K_WORD
    && DATA_BUS_LANES_OE_OUT == LANES_ALL
    |-> DATA_BUS_LANES_OUT == $past(rd))
    else $error("word lanes out of order");
  task_byte_a: assert property (TASKFILE_SEL_OUT || CONTROL_SEL_OUT
    |-> CORE_BYTE_EN_OUT == BE_EVEN
    && (DATA_BUS_LANES_OE_OUT & LANES_HI) == LANES_NONE)
    else $error("task file access not on low lanes");
  dma_word_a: assert property (ACCESS_KIND_OUT == K_DMA
    |-> CORE_BYTE_EN_OUT == BE_WORD && !TASKFILE_SEL_OUT)
    else $error("DMA transfer not a word");
  reg_idx_a: assert property (past_ok_q && TASKFILE_SEL_OUT
    |-> REG_INDEX_OUT == $past(stab_q.addr))
    else $error("register index wrong");
  float_a: assert property (ACCESS_KIND_OUT == K_NONE
    |-> DATA_BUS_LANES_OE_OUT == LANES_NONE)
    else $error("bus driven while deselected");

  word_read_c: cover property (ACCESS_KIND_OUT == K_WORD
    && DATA_BUS_LANES_OE_OUT == LANES_ALL);
  odd_low_c: cover property (ACCESS_KIND_OUT == K_ODD_LO);
  task_c: cover property (TASKFILE_SEL_OUT ##1 CONTROL_SEL_OUT);
  dma_c: cover property (ACCESS_KIND_OUT == K_DMA);

endmodule : csls_top

`default_nettype wire

/* testbench/csls_host_model.sv */
// Host controller model: card selects, strap and its share of the lanes.
// Assumes the card's lane drive and enables come back on the same cycle.
`timescale 1ns/1ps
`default_nettype none

module csls_host_model (
  // Clock
  input  wire logic                clk_in,
  // Card drive
  input  wire logic [15:0]         card_data_in,
  input  wire logic [15:0]         card_oe_in,
  // Pins seen by the card
  output var  csls_pkg::csls_pins_t pins_out
);
  import csls_pkg::*;

  csls_pins_t  req_q = PINS_IDLE;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] bus;

  ////////////////////////////////////////////////////////////////////////
  // No pull on the lanes: an undriven lane flips every cycle.
  // A writing host wins over a card still draining its last read drive,
  // which lags the read qualifier by the pin synchroniser.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (req_q.rd_n)
        bus[i] = req_q.data[i];
      else if (card_oe_in[i])
        bus[i] = card_data_in[i];
      else
        bus[i] = ~last_q[i];
    end
    pins_out = req_q;
    pins_out.data = bus;
  end

  always @(posedge clk_in) last_q <= bus;

  ////////////////////////////////////////////////////////////////////////
  // Selects are negated and the transfer is a word while granted
  task automatic access(input logic even_n, odd_n, offset, grant_n, rd_n,
                        input logic [2:0] addr, input logic [15:0] data);
    @(negedge clk_in);
    req_q.even_en_n = even_n | ~grant_n;
    req_q.odd_en_n = odd_n | ~grant_n;
    req_q.offset = offset;
    req_q.addr = addr;
    req_q.grant_n = grant_n;
    req_q.rd_n = rd_n;
    req_q.data = data;
  endtask

  // Open strap is driven 1 in place of the pull-up
  task automatic strap(input logic role_n);
    req_q.role_n = role_n;
  endtask
endmodule // csls_host_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the select decode and lane steering block.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import csls_pkg::*;

  typedef struct packed {
    csls_kind_t kind;
    logic [1:0] be;
    logic tf, cb;
    logic [2:0] idx;
    logic master;
    logic [15:0] oe, dout, wr, wmask;
  } csls_exp_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  csls_mode_t card_mode = MODE_MEM;
  logic [15:0] core_rd = 16'h0000;
  csls_pins_t pins;
  logic [15:0] lanes_out, lanes_oe, wr_out;
  logic [1:0] be_out;
  csls_kind_t kind_out;
  logic tf_out, cb_out, master_out, master_exp = 1'b0;
  logic [2:0] idx_out;
  csls_exp_t q[$];
  csls_exp_t me;
  event chk_ev;
  int fails = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;

  csls_host_model csls_host_model_i (.clk_in(clk), .card_data_in(lanes_out),
    .card_oe_in(lanes_oe), .pins_out(pins));

  csls_top csls_top_i (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .CARD_MODE_IN(card_mode), .EVEN_LANE_ENABLE_N_IN(pins.even_en_n),
    .ODD_LANE_ENABLE_N_IN(pins.odd_en_n), .BYTE_OFFSET_BIT_IN(pins.offset),
    .REG_ADDR_IN(pins.addr), .ROLE_SELECT_N_IN(pins.role_n),
    .DMA_GRANT_N_IN(pins.grant_n), .HOST_READ_N_IN(pins.rd_n),
    .DATA_BUS_LANES_IN(pins.data), .DATA_BUS_LANES_OUT(lanes_out),
    .DATA_BUS_LANES_OE_OUT(lanes_oe), .CORE_RD_DATA_IN(core_rd),
    .CORE_WR_DATA_OUT(wr_out), .CORE_BYTE_EN_OUT(be_out),
    .ACCESS_KIND_OUT(kind_out), .TASKFILE_SEL_OUT(tf_out),
    .CONTROL_SEL_OUT(cb_out), .REG_INDEX_OUT(idx_out),
    .ROLE_MASTER_OUT(master_out));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One access: note the expected decode, then let the monitor compare
  task automatic go(input csls_mode_t m, input logic ev, od, ofs, dk, rd,
                    input logic [2:0] ad);
    csls_exp_t e;
    logic [15:0] rdw, wd, ln;
    rdw = 16'($urandom);
    wd = 16'($urandom);
    e = '0;
    e.master = master_exp;
    ln = LANES_LO;
    if (m == MODE_IDE && !dk) begin
      e.kind = K_DMA;
      ln = LANES_ALL;
    end else if (!ev && !od) begin
      e.kind = K_WORD;
      ln = LANES_ALL;
    end else if (m == MODE_IDE && !ev) begin
      e.kind = K_TASK;
      e.tf = 1'b1;
      e.idx = ad;
    end else if (m == MODE_IDE && !od) begin
      e.kind = K_CTRL;
      e.cb = 1'b1;
      e.idx = ad;
    end else if (!od) begin
      e.kind = K_ODD_HI;
      ln = LANES_HI;
    end else if (!ev)
      e.kind = ofs ? K_ODD_LO : K_EVEN;
    else
      ln = LANES_NONE;
    e.be = (ln == LANES_ALL) ? BE_WORD : (ln == LANES_NONE) ? BE_NONE :
           (ln == LANES_HI || e.kind == K_ODD_LO) ? BE_ODD : BE_EVEN;
    e.oe = rd ? LANES_NONE : ln;
    e.dout = (e.kind == K_ODD_LO) ? {BYTE_ZERO, rdw[15:8]} : rdw & ln;
    e.wmask = !rd ? LANES_NONE : (e.kind == K_ODD_LO) ? LANES_HI : ln;
    e.wr = (e.kind == K_ODD_LO) ? {wd[7:0], BYTE_ZERO} : wd & ln;
    e.wr = e.wr & e.wmask;
    @(negedge clk);
    card_mode = m;
    core_rd = rdw;
    csls_host_model_i.access(ev, od, ofs, dk, rd, ad, wd);
    repeat (6) @(negedge clk);
    q.push_back(e);
    ->chk_ev;
  endtask

  task automatic do_reset(input csls_mode_t m, input logic role_n, mst);
    @(negedge clk);
    rst_n = 1'b0;
    card_mode = m;
    csls_host_model_i.strap(role_n);
    repeat (12) @(negedge clk);
    check("reset_oe", lanes_oe, LANES_NONE);
    check("reset_kind", kind_out, K_NONE);
    rst_n = 1'b1;
    master_exp = mst;
    repeat (12) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(chk_ev) begin
    me = q.pop_front();
    check("kind", kind_out, me.kind);
    check("byte_en", be_out, me.be);
    check("drive_en", lanes_oe, me.oe);
    check("read_lanes", lanes_out & me.oe, me.dout & me.oe);
    check("write_word", wr_out & me.wmask, me.wr);
    check("selects", {tf_out, cb_out}, {me.tf, me.cb});
    check("reg_index", idx_out, me.idx);
    check("role", master_out, me.master);
  end

  initial begin
    #75000;
    fails++;
    conclude;
  end

  initial begin
    void'($urandom(27540));
    do_reset(MODE_MEM, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
      for (int c = 0; c < 16; c++)
        go(k ? MODE_IO : MODE_MEM, c[3], c[2], c[1], 1'b1, c[0],
           3'($urandom));
    $display("test mem_io done");
    do_reset(MODE_IDE, 1'b0, 1'b1);
    for (int c = 0; c < 16; c++)
      go(MODE_IDE, c[3], c[2], 1'($urandom), c[1], c[0], 3'($urandom));
    $display("test ide_master done");
    do_reset(MODE_IDE, 1'b1, 1'b0);
    for (int c = 0; c < 8; c++)
      go(MODE_IDE, c[2], ~c[2], 1'b0, c[1], c[0], 3'(c));
    $display("test ide_slave done");
    conclude;
  end
endmodule // testbench
`default_nettype wire
